// File: hw/cond_branch_regs.svh
// Constants for the conditional branch evaluator
`ifndef COND_BRANCH_REGS_SVH
`define COND_BRANCH_REGS_SVH

// Status register bit positions
`define CBE_FLAG_C 0
`define CBE_FLAG_Z 1
`define CBE_SREG_W 8

// Program counter and offset widths
`define CBE_PC_W 16
`define CBE_OFS_W 7
`define CBE_PC_RESET 16'h0000

// Cycles from issue to completion
`define CBE_CYC_NOT_TAKEN 1
`define CBE_CYC_TAKEN 2

`endif

// File: hw/cond_branch_pkg.sv
// Types for the conditional branch evaluator
`default_nettype none
package cond_branch_pkg;

  typedef enum logic [2:0] {
    op_none                  = 3'h0,
    op_branch_not_equal      = 3'h1,
    op_branch_carry_set      = 3'h2,
    op_branch_carry_clear    = 3'h3,
    op_branch_same_or_higher = 3'h4,
    op_branch_lower          = 3'h5
  } branch_op_e;

  typedef enum logic [0:0] {
    st_idle  = 1'h0,
    st_taken = 1'h1
  } branch_state_e;

endpackage
`default_nettype wire

// File: hw/cond_if.sv
// Carrier between the branch sequencer and the flag test
`default_nettype none
interface cond_if;
  cond_branch_pkg::branch_op_e op;
  logic [7:0] sreg;
  logic take;

  modport eval (
    input op,
    input sreg,
    output take
  );
  modport core (
    output op,
    output sreg,
    input take
  );
endinterface
`default_nettype wire

// File: hw/branch_cond.sv
// Flag test for the conditional branch group
`include "cond_branch_regs.svh"
`default_nettype none
module branch_cond (
  cond_if.eval cif
);

  always_comb begin
    case (cif.op)
      cond_branch_pkg::op_branch_not_equal:
        cif.take = ~cif.sreg[`CBE_FLAG_Z];
      cond_branch_pkg::op_branch_carry_set,
      cond_branch_pkg::op_branch_lower:
        cif.take = cif.sreg[`CBE_FLAG_C];
      cond_branch_pkg::op_branch_carry_clear,
      cond_branch_pkg::op_branch_same_or_higher:
        cif.take = ~cif.sreg[`CBE_FLAG_C];
      default:
        cif.take = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// File: hw/branch_unit.sv
// Conditional relative branch sequencer
//
// How it works
// - Not-equal branch is taken only while the zero flag is 0.
// - Carry-set branch is taken only while the carry flag is 1.
// - Carry-clear branch is taken only while the carry flag is 0.
// - Same-or-higher tests carry clear; lower tests carry set.
// - Taken target is current PC plus signed offset plus one.
`include "cond_branch_regs.svh"
`default_nettype none
module branch_unit (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_valid,
  input wire cond_branch_pkg::branch_op_e i_op,
  input wire logic [`CBE_OFS_W-1:0] i_offset,
  input wire logic [`CBE_PC_W-1:0] i_pc,
  input wire logic [`CBE_SREG_W-1:0] i_sreg,
  output logic o_busy,
  output logic o_done,
  output logic o_taken,
  output logic o_pc_load,
  output logic [`CBE_PC_W-1:0] o_pc_next,
  output logic o_sreg_we
);

  typedef struct packed {
    cond_branch_pkg::branch_state_e fsm;
    logic busy;
    logic done;
    logic taken;
    logic pc_load;
    logic sreg_we;
    logic [`CBE_PC_W-1:0] target;
    logic [`CBE_PC_W-1:0] pc_next;
  } unit_s;

  unit_s st;
  unit_s next_st;
  logic accept;
  logic [`CBE_PC_W-1:0] ofs_ext;

  cond_if cif ();

  assign cif.op = i_op;
  assign cif.sreg = i_sreg;

  branch_cond u_cond (
    .cif(cif)
  );

  // Requests during the first (busy) cycle of a taken branch are dropped
  // Codes 6 and 7 count as no request, like code 0
  assign accept = i_valid && !st.busy &&
                  (i_op >= cond_branch_pkg::op_branch_not_equal) &&
                  (i_op <= cond_branch_pkg::op_branch_lower);
  assign ofs_ext = {{(`CBE_PC_W-`CBE_OFS_W){i_offset[`CBE_OFS_W-1]}},
                    i_offset};

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.taken = 1'b0;
    next_st.pc_load = 1'b0;
    next_st.sreg_we = 1'b0;
    case (st.fsm)
      cond_branch_pkg::st_idle: begin
        if (accept) begin
          if (cif.take) begin
            // Target held so the PC load lands in the second cycle
            next_st.target = i_pc + ofs_ext + `CBE_PC_W'(1);
            next_st.fsm = cond_branch_pkg::st_taken;
            next_st.busy = 1'b1;
          end else begin
            next_st.pc_next = i_pc + `CBE_PC_W'(1);
            next_st.pc_load = 1'b1;
            next_st.done = 1'b1;
          end
        end
      end
      cond_branch_pkg::st_taken: begin
        next_st.pc_next = st.target;
        next_st.pc_load = 1'b1;
        next_st.done = 1'b1;
        next_st.taken = 1'b1;
        next_st.busy = 1'b0;
        next_st.fsm = cond_branch_pkg::st_idle;
      end
      default: begin
        next_st.fsm = cond_branch_pkg::st_idle;
        next_st.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '0;
      st.target <= `CBE_PC_RESET;
      st.pc_next <= `CBE_PC_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign o_busy = st.busy;
  assign o_done = st.done;
  assign o_taken = st.taken;
  assign o_pc_load = st.pc_load;
  assign o_pc_next = st.pc_next;
  assign o_sreg_we = st.sreg_we;

  // Checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);

  logic iss_ne;
  logic iss_cs;
  logic iss_cc;
  logic iss_sh;
  logic iss_lo;
  assign iss_ne = accept && i_op == cond_branch_pkg::op_branch_not_equal;
  assign iss_cs = accept && i_op == cond_branch_pkg::op_branch_carry_set;
  assign iss_cc = accept && i_op == cond_branch_pkg::op_branch_carry_clear;
  assign iss_sh = accept &&
                  i_op == cond_branch_pkg::op_branch_same_or_higher;
  assign iss_lo = accept && i_op == cond_branch_pkg::op_branch_lower;

  sequence s_taken_done;
    !o_done ##1 (o_done && o_taken && o_pc_load);
  endsequence

  sequence s_skip_done;
    o_done && !o_taken && o_pc_load;
  endsequence

  // Flag tests, checked at the accepting edge
  a_not_equal_eval: assert property (
    iss_ne |-> cif.take == !i_sreg[`CBE_FLAG_Z] )
    else $error("not-equal branch condition wrong");
  a_not_equal_seq: assert property (
    iss_ne && !i_sreg[`CBE_FLAG_Z] |=> s_taken_done )
    else $error("not-equal branch not taken with zero clear");
  a_not_equal_skip: assert property (
    iss_ne && i_sreg[`CBE_FLAG_Z] |=> o_done && !o_taken )
    else $error("not-equal branch taken with zero set");
  a_carry_set_eval: assert property (
    iss_cs |-> cif.take == i_sreg[`CBE_FLAG_C] )
    else $error("carry-set branch condition wrong");
  a_carry_set_seq: assert property (
    iss_cs && i_sreg[`CBE_FLAG_C] |=> s_taken_done )
    else $error("carry-set branch not taken with carry set");
  a_carry_set_skip: assert property (
    iss_cs && !i_sreg[`CBE_FLAG_C] |=> s_skip_done )
    else $error("carry-set branch taken with carry clear");
  a_carry_clear_seq: assert property (
    iss_cc && i_sreg[`CBE_FLAG_C] |=> o_done && !o_taken &&
      o_pc_next == $past(i_pc) + `CBE_PC_W'(1) )
    else $error("carry-clear branch taken with carry set");
  a_carry_clear_eval: assert property (
    iss_cc |-> cif.take == !i_sreg[`CBE_FLAG_C] )
    else $error("carry-clear branch condition wrong");
  a_carry_clear_take: assert property (
    iss_cc && !i_sreg[`CBE_FLAG_C] |=> s_taken_done )
    else $error("carry-clear branch not taken with carry clear");
  // Unsigned aliases must behave exactly like their carry twins
  a_same_higher_take: assert property (
    iss_sh && !i_sreg[`CBE_FLAG_C] |=> s_taken_done )
    else $error("same-or-higher branch not taken with carry clear");
  a_same_higher_skip: assert property (
    iss_sh && i_sreg[`CBE_FLAG_C] |=> s_skip_done )
    else $error("same-or-higher branch taken with carry set");
  a_lower_take: assert property (
    iss_lo && i_sreg[`CBE_FLAG_C] |=> s_taken_done )
    else $error("lower branch not taken with carry set");
  a_lower_skip: assert property (
    iss_lo && !i_sreg[`CBE_FLAG_C] |=> s_skip_done )
    else $error("lower branch taken with carry clear");
  a_alias_flags: assert property (
    accept && (i_op == cond_branch_pkg::op_branch_same_or_higher ||
      i_op == cond_branch_pkg::op_branch_lower) |->
      cif.take == ((i_op == cond_branch_pkg::op_branch_lower) ==
                   i_sreg[`CBE_FLAG_C]) )
    else $error("unsigned branch not aliased to carry test");
  a_target_calc: assert property (
    o_done && o_taken |-> o_pc_next == $past(i_pc, 2) +
      {{(`CBE_PC_W-`CBE_OFS_W){$past(i_offset[`CBE_OFS_W-1], 2)}},
       $past(i_offset, 2)} + `CBE_PC_W'(1) )
    else $error("taken branch target wrong");
  a_flags_kept: assert property (
    accept |-> !o_sreg_we ##1 !o_sreg_we ##1 !o_sreg_we )
    else $error("branch wrote status flags");
  a_taken_busy: assert property (
    accept && cif.take |=> o_busy ##1 (!o_busy && o_done) )
    else $error("taken branch not two cycles");

  // Timing and PC bus
  a_busy_one_cycle: assert property (
    o_busy |=> !o_busy && o_done && o_taken )
    else $error("busy cycle not followed by taken answer");
  // Refused and unused codes leave no trace at the ports
  a_idle_no_done: assert property (
    !o_busy && !accept |=> !o_done )
    else $error("answer without an accepted request");
  a_skip_pc: assert property (
    accept && !cif.take |=> o_pc_next == $past(i_pc) + `CBE_PC_W'(1) )
    else $error("not-taken branch does not step the PC");
  a_pulses_paired: assert property (
    o_pc_load == o_done && (o_done || !o_taken) )
    else $error("answer pulses out of step");
  // The core may sample the PC bus at any time, so it must hold
  a_pc_next_hold: assert property (
    !o_pc_load |-> $stable(o_pc_next) )
    else $error("PC bus changed without a load");

  c_ne_taken: cover property (iss_ne && !i_sreg[`CBE_FLAG_Z] ##2 o_taken);
  c_cs_not_taken: cover property (iss_cs && !i_sreg[`CBE_FLAG_C]);
  c_back_to_back: cover property (o_done && !o_taken ##0 accept);
  c_refused: cover property (i_valid && o_busy);
  c_lower_taken: cover property (iss_lo && i_sreg[`CBE_FLAG_C] ##2 o_taken);

endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the conditional branch sequencer
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys;
  logic i_arst_n;
  logic i_valid;
  cond_branch_pkg::branch_op_e i_op;
  logic [6:0] i_offset;
  logic [15:0] i_pc;
  logic [15:0] o_pc_next;
  logic [7:0] i_sreg;
  logic o_busy, o_done, o_taken, o_pc_load, o_sreg_we;
  int n_errors = 0;
  int compares = 0;
  // Row: op, status, offset, pc, expected taken
  logic [34:0] rows [12] = '{
    {3'h1, 8'h00, 7'h3F, 16'h1000, 1'b1},
    {3'h1, 8'h02, 7'h3F, 16'h1000, 1'b0},
    {3'h1, 8'hFD, 7'h40, 16'h0010, 1'b1},
    {3'h2, 8'h01, 7'h7F, 16'h0100, 1'b1},
    {3'h2, 8'hFE, 7'h01, 16'h0100, 1'b0},
    {3'h3, 8'h00, 7'h01, 16'hFFFF, 1'b1},
    {3'h3, 8'h01, 7'h01, 16'hFFFF, 1'b0},
    {3'h4, 8'hFE, 7'h05, 16'h0200, 1'b1},
    {3'h4, 8'h01, 7'h05, 16'h0200, 1'b0},
    {3'h5, 8'h01, 7'h70, 16'h0300, 1'b1},
    {3'h5, 8'hFE, 7'h70, 16'h0300, 1'b0},
    {3'h5, 8'h03, 7'h00, 16'h0400, 1'b1}
  };
  logic [2:0] ignored [3] = '{3'h0, 3'h6, 3'h7};

  branch_unit u_branch_unit (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_valid(i_valid),
    .i_op(i_op),
    .i_offset(i_offset),
    .i_pc(i_pc),
    .i_sreg(i_sreg),
    .o_busy(o_busy),
    .o_done(o_done),
    .o_taken(o_taken),
    .o_pc_load(o_pc_load),
    .o_pc_next(o_pc_next),
    .o_sreg_we(o_sreg_we)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  task automatic wrap_up;
    $display("Errors %0d, compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Bounded wait for completion; a missing answer shows as a wrong count
  task automatic run(input logic [34:0] r);
    int n;
    logic [15:0] exp_pc;
    @(negedge i_clk_sys);
    i_op = cond_branch_pkg::branch_op_e'(r[34:32]);
    i_sreg = r[31:24];
    i_offset = r[23:17];
    i_pc = r[16:1];
    i_valid = 1'b1;
    exp_pc = r[16:1] + 16'h0001;
    if (r[0]) exp_pc = exp_pc + {{9{r[23]}}, r[23:17]};
    @(negedge i_clk_sys);
    i_valid = 1'b0;
    n = 1;
    while (o_done !== 1'b1 && n < 4) begin
      `CHK(o_busy, r[0])
      @(negedge i_clk_sys);
      n++;
    end
    `CHK(n, r[0] ? 2 : 1)
    `CHK(o_taken, r[0])
    `CHK({o_pc_load, o_pc_next}, {1'b1, exp_pc})
    `CHK(o_sreg_we, 1'b0)
    @(negedge i_clk_sys);
    `CHK({o_done, o_taken, o_pc_load, o_busy}, 4'h0)
  endtask

  initial begin
    i_arst_n = 1'b0;
    i_valid = 1'b0;
    i_op = cond_branch_pkg::op_none;
    i_offset = 7'h00;
    i_pc = 16'h0000;
    i_sreg = 8'h00;
    repeat (3) @(negedge i_clk_sys);
    `CHK({o_busy, o_done, o_taken, o_pc_load, o_sreg_we, o_pc_next}, 21'h0)
    i_arst_n = 1'b1;
    foreach (rows[i]) run(rows[i]);
    // Unused op codes must never answer, even with every flag clear
    foreach (ignored[i]) begin
      @(negedge i_clk_sys);
      i_op = cond_branch_pkg::branch_op_e'(ignored[i]);
      i_sreg = 8'h00;
      i_valid = 1'b1;
      repeat (3) begin
        @(negedge i_clk_sys);
        `CHK(o_done, 1'b0)
      end
    end
    // Two not-taken branches back to back
    i_op = cond_branch_pkg::op_branch_carry_clear;
    i_sreg = 8'h01;
    i_pc = 16'h0020;
    @(negedge i_clk_sys);
    i_pc = 16'h0030;
    `CHK({o_done, o_pc_next}, 17'h10021)
    @(negedge i_clk_sys);
    i_valid = 1'b0;
    `CHK({o_done, o_pc_next}, 17'h10031)
    // A request held through the busy cycle is refused
    @(negedge i_clk_sys);
    i_op = cond_branch_pkg::op_branch_not_equal;
    i_sreg = 8'h00;
    i_offset = 7'h10;
    i_pc = 16'h0100;
    i_valid = 1'b1;
    @(negedge i_clk_sys);
    i_op = cond_branch_pkg::op_branch_carry_clear;
    i_sreg = 8'h01;
    i_pc = 16'h0200;
    `CHK(o_busy, 1'b1)
    @(negedge i_clk_sys);
    i_valid = 1'b0;
    `CHK({o_done, o_taken, o_pc_next}, 18'h30111)
    @(negedge i_clk_sys);
    `CHK({o_done, o_pc_next}, 17'h00111)
    // Reset in the middle of a taken branch
    i_op = cond_branch_pkg::op_branch_not_equal;
    i_sreg = 8'h00;
    i_valid = 1'b1;
    @(negedge i_clk_sys);
    i_valid = 1'b0;
    `CHK(o_busy, 1'b1)
    i_arst_n = 1'b0;
    @(negedge i_clk_sys);
    `CHK({o_busy, o_done, o_taken, o_pc_load, o_sreg_we, o_pc_next}, 21'h0)
    i_arst_n = 1'b1;
    @(negedge i_clk_sys);
    `CHK({o_busy, o_done, o_pc_load}, 3'h0)
    run(rows[0]);
    @(negedge i_clk_sys);
    wrap_up();
  end
endmodule
`default_nettype wire
